// ===== hdl/cab_pkg.sv
package cab_pkg;
	// Datapath widths.
	localparam int WORD_W = 16;
	localparam int INSN_W = 24;
	localparam int OPC_W = 8;
	localparam int NUM_DEFAULT_WORK_REG = 16;
	localparam int REG_IDX_W = 4;
	localparam int FILE_ADDR_W = 13;
	localparam logic [FILE_ADDR_W-1:0] FILE_ADDR_MAX = 13'h1fff;
	localparam logic [9:0] UNSIGNED_LITERAL_TEN_BYTE_MAX = 10'h0ff;
	localparam logic [9:0] UNSIGNED_LITERAL_TEN_WORD_MAX = 10'h3ff;
	localparam logic [REG_IDX_W-1:0] DEFAULT_WORK_REG_IDX = 4'h0;
	// Reset values.
	localparam logic [WORD_W-1:0] DEFAULT_WORK_REG_RST = 16'h0000;
	localparam logic [4:0] FLAGS_RST = 5'h00;
	// Cycle counts.
	localparam logic [1:0] CYC_ONE = 2'h1;
	localparam logic [1:0] CYC_TWO = 2'h2;
	localparam logic [1:0] CYC_THREE = 2'h3;
	// Operation codes seen on the decoded operation port.
	typedef enum logic [3:0] {
		CAB_OP_NOP,
		CAB_OP_ADD,
		CAB_OP_ADD_WITH_CARRY,
		CAB_OP_ASR1,
		CAB_OP_ASR_BY_REG,
		CAB_OP_BIT_SET,
		CAB_OP_BIT_CLEAR,
		CAB_OP_BIT_TOGGLE,
		CAB_OP_BIT_TEST_SKIP_CLEAR,
		CAB_OP_BRANCH_COND,
		CAB_OP_BRANCH_ALWAYS,
		CAB_OP_BRANCH_COMPUTED
	} cab_op_t;
	// Branch conditions.
	typedef enum logic [3:0] {
		CAB_CC_C, CAB_CC_NC, CAB_CC_N, CAB_CC_NN, CAB_CC_OV, CAB_CC_NOV,
		CAB_CC_Z, CAB_CC_NZ, CAB_CC_GT, CAB_CC_GE, CAB_CC_LT, CAB_CC_LE,
		CAB_CC_GTU, CAB_CC_GEU, CAB_CC_LTU, CAB_CC_LEU
	} cab_cond_t;
	// Addressing modes of a register operand.
	typedef enum logic [2:0] {
		CAB_AM_DIRECT, CAB_AM_IND, CAB_AM_IND_POSTINC, CAB_AM_IND_POSTDEC,
		CAB_AM_IND_PREINC, CAB_AM_IND_PREDEC, CAB_AM_IND_OFFSET
	} cab_amode_t;
	// Operand size.
	typedef enum logic [1:0] {
		CAB_SZ_WORD, CAB_SZ_BYTE, CAB_SZ_DWORD
	} cab_size_t;
	// Flag positions in the status vector.
	localparam int FLG_C = 0;
	localparam int FLG_DC = 1;
	localparam int FLG_N = 2;
	localparam int FLG_OV = 3;
	localparam int FLG_Z = 4;
endpackage

// ===== hdl/cab_alu_branch.sv
`timescale 1ns/1ns
module cab_alu_branch
	import cab_pkg::*;
(
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic issue,
	input wire logic [INSN_W-1:0] insn_word,
	input wire cab_op_t op,
	input wire cab_cond_t cond,
	input wire cab_size_t op_size,
	input wire logic use_file_reg,
	input wire logic file_to_work,
	input wire logic [FILE_ADDR_W-1:0] file_addr,
	input wire logic [WORD_W-1:0] file_rdata,
	input wire logic [REG_IDX_W-1:0] base_reg,
	input wire logic [REG_IDX_W-1:0] source_reg,
	input wire logic [REG_IDX_W-1:0] dest_reg,
	input wire cab_amode_t src_mode,
	input wire cab_amode_t dst_mode,
	input wire logic use_literal,
	input wire logic lit_signed,
	input wire logic [9:0] lit_value,
	input wire logic [3:0] bit_select_field,
	input wire logic [22:0] program_target_literal,
	input wire logic skip_two_word,
	output logic busy,
	output logic file_we,
	output logic [FILE_ADDR_W-1:0] file_waddr,
	output logic [WORD_W-1:0] file_wdata,
	output logic [WORD_W-1:0] ea_out,
	output logic pc_load,
	output logic [22:0] pc_target,
	output logic [4:0] status_flags,
	output logic [7:0] opcode_seen
);

	// Working register file and status bits.
	logic [WORD_W-1:0] default_work_reg_r [NUM_DEFAULT_WORK_REG];
	logic [4:0] flags_r;
	logic [1:0] stall_r;
	logic [WORD_W-1:0] res_nxt;
	logic [4:0] flags_nxt;
	logic wr_nxt;
	logic branch_nxt;
	logic [1:0] extra_nxt;
	logic [WORD_W-1:0] opa;
	logic [WORD_W-1:0] opb;
	logic [WORD_W-1:0] lit_ext;
	logic [WORD_W:0] sum;
	logic [4:0] half_sum;
	logic cin;
	logic [WORD_W-1:0] ptr;
	logic [WORD_W-1:0] ptr_nxt;
	logic ptr_wr;
	logic [WORD_W-1:0] mask;
	logic [WORD_W-1:0] ea_nxt;

	// Condition evaluation is used only by the conditional branch form, kept as a function.
	// signed unsigned conditions
	function automatic logic cond_true(input cab_cond_t c, input logic [4:0] f);
		logic cy;
		logic ng;
		logic ov;
		logic zr;
		cy = f[FLG_C];
		ng = f[FLG_N];
		ov = f[FLG_OV];
		zr = f[FLG_Z];
		case (c)
			CAB_CC_C: cond_true = cy;
			CAB_CC_NC: cond_true = !cy;
			CAB_CC_N: cond_true = ng;
			CAB_CC_NN: cond_true = !ng;
			CAB_CC_OV: cond_true = ov;
			CAB_CC_NOV: cond_true = !ov;
			CAB_CC_Z: cond_true = zr;
			CAB_CC_NZ: cond_true = !zr;
			CAB_CC_GT: cond_true = !zr && (ng == ov);
			CAB_CC_GE: cond_true = (ng == ov);
			CAB_CC_LT: cond_true = (ng != ov);
			CAB_CC_LE: cond_true = zr || (ng != ov);
			CAB_CC_GTU: cond_true = cy && !zr;
			CAB_CC_GEU: cond_true = cy;
			CAB_CC_LTU: cond_true = !cy;
			CAB_CC_LEU: cond_true = !cy || zr;
			default: cond_true = 1'b0;
		endcase
	endfunction

	// Literal shaping: signed literals extend the sign, unsigned ones are clipped by size.
	// signed literal range
	always_comb begin
		if (lit_signed) begin
			lit_ext = {{(WORD_W-10){lit_value[9]}}, lit_value};
		end else if (op_size == CAB_SZ_BYTE) begin
			lit_ext = {6'h00, lit_value & UNSIGNED_LITERAL_TEN_BYTE_MAX};
		end else begin
			lit_ext = {6'h00, lit_value & UNSIGNED_LITERAL_TEN_WORD_MAX};
		end
	end

	// Operand selection; file forms pair the file value with working register zero.
	// implied work register
	always_comb begin
		if (use_file_reg) begin
			opa = file_rdata;
			opb = default_work_reg_r[DEFAULT_WORK_REG_IDX];
		end else begin
			opa = default_work_reg_r[base_reg];
			opb = use_literal ? lit_ext : default_work_reg_r[source_reg];
		end
	end

	// Pointer update for the source operand addressing modes.
	// indirect pointer modes
	always_comb begin
		ptr = default_work_reg_r[source_reg];
		ptr_nxt = ptr;
		ptr_wr = 1'b0;
		ea_nxt = ptr;
		case (src_mode)
			CAB_AM_IND_POSTINC: begin
				ptr_nxt = ptr + 16'h0002;
				ptr_wr = 1'b1;
			end
			CAB_AM_IND_POSTDEC: begin
				ptr_nxt = ptr - 16'h0002;
				ptr_wr = 1'b1;
			end
			CAB_AM_IND_PREINC: begin
				ptr_nxt = ptr + 16'h0002;
				ea_nxt = ptr_nxt;
				ptr_wr = 1'b1;
			end
			CAB_AM_IND_PREDEC: begin
				ptr_nxt = ptr - 16'h0002;
				ea_nxt = ptr_nxt;
				ptr_wr = 1'b1;
			end
			CAB_AM_IND_OFFSET: ea_nxt = ptr + default_work_reg_r[base_reg];
			default: ea_nxt = ptr;
		endcase
	end

	// Adder and flag computation for each executed operation.
	always_comb begin
		cin = 1'b0;
		res_nxt = opa;
		flags_nxt = flags_r;
		wr_nxt = 1'b0;
		branch_nxt = 1'b0;
		extra_nxt = 2'h0;
		mask = 16'h0001 << bit_select_field;
		sum = '0;
		half_sum = '0;
		if (op == CAB_OP_ADD_WITH_CARRY) begin
			cin = flags_r[FLG_C];
		end
		case (op)
			CAB_OP_ADD, CAB_OP_ADD_WITH_CARRY: begin
				sum = {1'b0, opa} + {1'b0, opb} + {16'h0000, cin};
				half_sum = {1'b0, opa[3:0]} + {1'b0, opb[3:0]} + {4'h0, cin};
				res_nxt = sum[WORD_W-1:0];
				wr_nxt = 1'b1;
				flags_nxt[FLG_C] = sum[WORD_W];
				flags_nxt[FLG_DC] = half_sum[4];
				flags_nxt[FLG_N] = sum[WORD_W-1];
				flags_nxt[FLG_OV] = (opa[WORD_W-1] == opb[WORD_W-1])
					&& (sum[WORD_W-1] != opa[WORD_W-1]);
				if (op == CAB_OP_ADD_WITH_CARRY) begin
					flags_nxt[FLG_Z] = flags_r[FLG_Z] && (sum[WORD_W-1:0] == 16'h0000);
				end else begin
					flags_nxt[FLG_Z] = (sum[WORD_W-1:0] == 16'h0000);
				end
			end
			CAB_OP_ASR1: begin
				res_nxt = {opa[WORD_W-1], opa[WORD_W-1:1]};
				wr_nxt = 1'b1;
				flags_nxt[FLG_C] = opa[0];
				flags_nxt[FLG_N] = res_nxt[WORD_W-1];
				flags_nxt[FLG_OV] = 1'b0;
				flags_nxt[FLG_Z] = (res_nxt == 16'h0000);
			end
			CAB_OP_ASR_BY_REG: begin
				res_nxt = 16'($signed(opa) >>> opb[3:0]);
				wr_nxt = 1'b1;
				flags_nxt[FLG_N] = res_nxt[WORD_W-1];
				flags_nxt[FLG_Z] = (res_nxt == 16'h0000);
			end
			CAB_OP_BIT_SET: begin
				res_nxt = opa | mask;
				wr_nxt = 1'b1;
			end
			CAB_OP_BIT_CLEAR: begin
				res_nxt = opa & ~mask;
				wr_nxt = 1'b1;
			end
			CAB_OP_BIT_TOGGLE: begin
				res_nxt = opa ^ mask;
				wr_nxt = 1'b1;
			end
			CAB_OP_BIT_TEST_SKIP_CLEAR: begin
				if ((opa & mask) == 16'h0000) begin
					extra_nxt = skip_two_word ? (CYC_THREE - CYC_ONE) : (CYC_TWO - CYC_ONE);
				end
			end
			CAB_OP_BRANCH_COND: begin
				if (cond_true(cond, flags_r)) begin
					branch_nxt = 1'b1;
					extra_nxt = CYC_TWO - CYC_ONE;
				end
			end
			CAB_OP_BRANCH_ALWAYS, CAB_OP_BRANCH_COMPUTED: begin
				branch_nxt = 1'b1;
				extra_nxt = CYC_TWO - CYC_ONE;
			end
			default: res_nxt = opa;
		endcase
		// Byte results keep the upper byte of the first operand; flags still see the full word.
		// operand size
		if (op_size == CAB_SZ_BYTE && wr_nxt) begin
			res_nxt = {opa[15:8], res_nxt[7:0]};
		end
	end

	// Stall counter: extra cycles are spent as no-operations, new issues ignored.
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			stall_r <= 2'h0;
		end else if (stall_r != 2'h0) begin
			stall_r <= stall_r - 2'h1;
		end else if (issue) begin
			stall_r <= extra_nxt;
		end
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			busy <= 1'b0;
		end else if (stall_r > 2'h1) begin
			busy <= 1'b1;
		end else begin
			busy <= (stall_r == 2'h0) && issue && (extra_nxt != 2'h0);
		end
	end

	// Status flags change only for accepted operations that define them.
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			flags_r <= FLAGS_RST;
		end else if (issue && stall_r == 2'h0) begin
			flags_r <= flags_nxt;
		end
	end

	assign status_flags = flags_r;

	// Working register writes; file forms may redirect into register zero.
	// Pointer update has the lowest priority so a result to the same register wins.
	generate
		for (genvar i = 0; i < NUM_DEFAULT_WORK_REG; i++) begin : g_default_work_reg
			always_ff @(posedge core_clk or negedge arst_n) begin
				if (!arst_n) begin
					default_work_reg_r[i] <= DEFAULT_WORK_REG_RST;
				end else if (issue && stall_r == 2'h0) begin
					if (wr_nxt && use_file_reg && file_to_work
						&& REG_IDX_W'(i) == DEFAULT_WORK_REG_IDX) begin
						default_work_reg_r[i] <= res_nxt;
					end else if (wr_nxt && !use_file_reg && dst_mode == CAB_AM_DIRECT
						&& REG_IDX_W'(i) == dest_reg) begin
						default_work_reg_r[i] <= res_nxt;
					end else if (ptr_wr && !use_file_reg && REG_IDX_W'(i) == source_reg) begin
						default_work_reg_r[i] <= ptr_nxt;
					end
				end
			end
		end
	endgenerate

	// File register write port and indirect result port.
	// file address span
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			file_we <= 1'b0;
			file_waddr <= '0;
			file_wdata <= '0;
			ea_out <= '0;
		end else begin
			file_we <= issue && stall_r == 2'h0 && wr_nxt
				&& ((use_file_reg && !file_to_work) || (!use_file_reg && dst_mode != CAB_AM_DIRECT));
			file_waddr <= use_file_reg ? (file_addr & FILE_ADDR_MAX) : ea_nxt[FILE_ADDR_W-1:0];
			file_wdata <= res_nxt;
			ea_out <= ea_nxt;
		end
	end

	// Branch target; the program target is always even.
	// even target
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			pc_load <= 1'b0;
			pc_target <= '0;
		end else begin
			pc_load <= issue && stall_r == 2'h0 && branch_nxt;
			if (op == CAB_OP_BRANCH_COMPUTED) begin
				pc_target <= {7'h00, default_work_reg_r[source_reg][15:1], 1'b0};
			end else begin
				pc_target <= {program_target_literal[22:1], 1'b0};
			end
		end
	end

	// Opcode field is captured for decode visibility.
	// opcode field
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			opcode_seen <= 8'h00;
		end else if (issue && stall_r == 2'h0) begin
			opcode_seen <= insn_word[INSN_W-1:INSN_W-OPC_W];
		end
	end

endmodule

// ===== bench/cab_alu_branch_sva.sv
`timescale 1ns/1ns
module cab_alu_branch_sva
	import cab_pkg::*;
(
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic issue,
	input wire cab_op_t op,
	input wire logic use_file_reg,
	input wire logic file_to_work,
	input wire logic [FILE_ADDR_W-1:0] file_addr,
	input wire logic [3:0] bit_select_field,
	input wire logic [22:0] program_target_literal,
	input wire logic file_we,
	input wire logic [FILE_ADDR_W-1:0] file_waddr,
	input wire logic [WORD_W-1:0] file_wdata,
	input wire logic pc_load,
	input wire logic [22:0] pc_target,
	input wire logic [4:0] status_flags
);
	// Every check runs on the core clock and sleeps while reset is held.
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!arst_n);
	pc_pulse_a: assert property (pc_load |=> !pc_load) else $error("pc_load held");
	pc_cause_a: assert property (pc_load |-> $past(issue) &&
		$past(op) inside {CAB_OP_BRANCH_COND, CAB_OP_BRANCH_ALWAYS, CAB_OP_BRANCH_COMPUTED})
		else $error("pc_load without a branch");
	pc_even_a: assert property (pc_load |-> !pc_target[0]) else $error("odd target");
	pc_lit_a: assert property (pc_load && $past(op) != CAB_OP_BRANCH_COMPUTED |->
		pc_target == ($past(program_target_literal) & 23'h7ffffe)) else $error("bad target");
	flag_hold_a: assert property ($changed(status_flags) |-> $past(issue) &&
		$past(op) inside {CAB_OP_ADD, CAB_OP_ADD_WITH_CARRY, CAB_OP_ASR1, CAB_OP_ASR_BY_REG})
		else $error("flags moved without arithmetic");
	shift_keep_a: assert property ($past(issue) && $past(op) == CAB_OP_ASR_BY_REG |->
		(status_flags & 5'h0b) == ($past(status_flags) & 5'h0b)) else $error("shift flags");
	asr_dc_a: assert property ($past(issue) && $past(op) == CAB_OP_ASR1 |->
		(status_flags & 5'h02) == ($past(status_flags) & 5'h02)) else $error("shift half carry");
	we_cause_a: assert property (file_we |-> $past(issue) &&
		!($past(use_file_reg) && $past(file_to_work))) else $error("stray file write");
	// write address; indirect forms write to the effective address instead.
	waddr_a: assert property (file_we && $past(use_file_reg) |->
		file_waddr == $past(file_addr)) else $error("file address wrong");
	bit_set_a: assert property (file_we && $past(op) == CAB_OP_BIT_SET |->
		file_wdata[$past(bit_select_field)]) else $error("bit not set");
endmodule
bind cab_alu_branch cab_alu_branch_sva sva_i (.core_clk, .arst_n, .issue, .op, .use_file_reg,
	.file_to_work,
	.file_addr, .bit_select_field, .program_target_literal, .file_we, .file_waddr, .file_wdata,
	.pc_load, .pc_target, .status_flags);

// ===== bench/tb.sv
`timescale 1ns/1ns
module tb import cab_pkg::*; ;
	logic core_clk, arst_n, issue, use_file_reg, file_to_work, use_literal, lit_signed;
	logic skip_two_word, busy, file_we, pc_load;
	logic [INSN_W-1:0] insn_word;
	cab_op_t op;
	cab_cond_t cond;
	cab_size_t op_size;
	cab_amode_t src_mode, dst_mode;
	logic [FILE_ADDR_W-1:0] file_addr, file_waddr;
	logic [WORD_W-1:0] file_rdata, file_wdata, ea_out;
	logic [REG_IDX_W-1:0] base_reg, source_reg, dest_reg;
	logic [9:0] lit_value;
	logic [3:0] bit_select_field;
	logic [22:0] program_target_literal, pc_target;
	logic [4:0] status_flags, fl;
	logic [7:0] opcode_seen;
	logic [22:0] g_we, g_wd, g_wa, g_fl, g_pcl, g_pc, g_opc, g_we2, g_ea, g_bz1, g_bz2;
	int bad_count, samples_checked;
	cab_alu_branch dut (.core_clk, .arst_n, .issue, .insn_word, .op, .cond, .op_size, .use_file_reg,
		.file_to_work, .file_addr, .file_rdata, .base_reg, .source_reg, .dest_reg, .src_mode,
		.dst_mode, .use_literal, .lit_signed, .lit_value, .bit_select_field,
		.program_target_literal, .skip_two_word, .busy, .file_we, .file_waddr, .file_wdata,
		.ea_out, .pc_load, .pc_target, .status_flags, .opcode_seen);
	// Core clock at 25 MHz.
	initial begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end
	task automatic conclude();
		$display("Checks %0d, errors %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task automatic chk(logic [22:0] g, logic [22:0] e);
		samples_checked++;
		if (g !== e) begin
			bad_count++;
			$display("Error at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	// Branch decision worked out from the flags, independent of the core.
	function automatic logic taken(cab_cond_t c, logic [4:0] f);
		logic ge, gt, gtu;
		ge = f[FLG_N] == f[FLG_OV];
		gt = ge && !f[FLG_Z];
		gtu = f[FLG_C] && !f[FLG_Z];
		case (c)
			CAB_CC_C, CAB_CC_NC: return f[FLG_C] ^ c[0];
			CAB_CC_N, CAB_CC_NN: return f[FLG_N] ^ c[0];
			CAB_CC_OV, CAB_CC_NOV: return f[FLG_OV] ^ c[0];
			CAB_CC_Z, CAB_CC_NZ: return f[FLG_Z] ^ c[0];
			CAB_CC_GT: return gt;
			CAB_CC_GE: return ge;
			CAB_CC_LT: return !ge;
			CAB_CC_LE: return !gt;
			CAB_CC_GTU: return gtu;
			CAB_CC_GEU: return f[FLG_C];
			CAB_CC_LTU: return !f[FLG_C];
			default: return !gtu;
		endcase
	endfunction
	// One issue, an optional request in the following cycle, then two idle edges.
	// The idle edges cover the longest stall, so callers need no spacing of their own.
	task automatic do_op(cab_op_t o, cab_cond_t c, logic [1:0] lm, logic [9:0] lit, logic f2w,
		cab_size_t sz, logic [15:0] rd, logic [3:0] bs, logic sk, cab_op_t nx);
		@(posedge core_clk);
		issue <= 1'b1;
		op <= o;
		cond <= c;
		{lit_signed, use_literal} <= lm;
		// Mode 2'b10 is the register form: no literal and no file register.
		use_file_reg <= (lm == 2'b00);
		lit_value <= lit;
		file_to_work <= f2w;
		op_size <= sz;
		file_rdata <= rd;
		file_addr <= rd[12:0] ^ FILE_ADDR_MAX;
		bit_select_field <= bs;
		skip_two_word <= sk;
		insn_word <= {4'ha, o, rd};
		program_target_literal <= {7'h24, rd};
		@(posedge core_clk);
		op <= nx;
		use_file_reg <= 1'b1;
		use_literal <= 1'b0;
		file_to_work <= 1'b0;
		issue <= (nx != CAB_OP_NOP);
		#1;
		g_we = 23'(file_we);
		g_wd = 23'(file_wdata);
		g_wa = 23'(file_waddr);
		g_fl = 23'(status_flags);
		g_pcl = 23'(pc_load);
		g_pc = pc_target;
		g_opc = 23'(opcode_seen);
		g_bz1 = 23'(busy);
		@(posedge core_clk);
		issue <= 1'b0;
		#1;
		g_we2 = 23'(file_we);
		g_ea = 23'(ea_out);
		g_bz2 = 23'(busy);
		@(posedge core_clk);
	endtask
	// Every condition is tried against the flags left by the last arithmetic step.
	task automatic conds();
		logic t;
		for (int i = 0; i < 16; i++) begin
			do_op(CAB_OP_BRANCH_COND, cab_cond_t'(i), 2'b00, 10'h0, 1'b0, CAB_SZ_WORD,
				16'h3457, 4'h0, 1'b0, CAB_OP_BIT_SET);
			t = taken(cab_cond_t'(i), fl);
			chk(g_pcl, 23'(t));
			chk(g_we2, 23'(!t));
			chk(g_bz1, 23'(t));
			chk(g_fl, 23'(fl));
			if (t) chk(g_pc, 23'h243456);
		end
	endtask
	task automatic ar(cab_op_t o, logic [1:0] lm, logic [9:0] lit, logic f2w, logic [15:0] rd,
		logic [22:0] wd, logic [4:0] ef);
		do_op(o, CAB_CC_C, lm, lit, f2w, CAB_SZ_WORD, rd, 4'h0, 1'b0, CAB_OP_NOP);
		chk(g_we, 23'(!f2w && !lm[0]));
		if (!f2w && !lm[0]) chk(g_wd, wd);
		if (!f2w && !lm[0]) chk(g_wa, 23'(rd[12:0] ^ FILE_ADDR_MAX));
		chk(g_fl, 23'(ef));
		chk(g_opc, 23'({4'ha, o}));
		fl = ef;
		conds();
	endtask
	task automatic bo(cab_op_t o, logic [15:0] rd, logic [3:0] bs, logic [22:0] wd);
		do_op(o, CAB_CC_C, 2'b00, 10'h0, 1'b0, CAB_SZ_WORD, rd, bs, 1'b0, CAB_OP_NOP);
		chk(g_wd, wd);
		chk(g_fl, 23'(fl));
	endtask
	// Hang guard, far beyond the roughly six hundred cycles the sequence needs.
	initial begin
		#2000000;
		bad_count++;
		conclude();
	end
	// Main sequence; working register zero starts at zero after reset.
	initial begin
		{issue, use_file_reg, file_to_work, use_literal, lit_signed, skip_two_word} = '0;
		{insn_word, file_addr, file_rdata, base_reg, source_reg, dest_reg} = '0;
		{lit_value, bit_select_field, program_target_literal} = '0;
		op = CAB_OP_NOP;
		cond = CAB_CC_C;
		op_size = CAB_SZ_WORD;
		src_mode = CAB_AM_DIRECT;
		dst_mode = CAB_AM_DIRECT;
		arst_n = 1'b0;
		repeat (12) @(posedge core_clk);
		arst_n <= 1'b1;
		#1;
		chk(23'({status_flags, file_we, pc_load}), 23'h0);
		ar(CAB_OP_ADD, 2'b01, 10'h3ff, 1'b0, 16'h0, 23'h0, 5'h00);
		ar(CAB_OP_ADD, 2'b11, 10'h200, 1'b0, 16'h0, 23'h0, 5'h01);
		ar(CAB_OP_ADD, 2'b00, 10'h0, 1'b1, 16'h7e00, 23'h0, 5'h00);
		ar(CAB_OP_ADD, 2'b00, 10'h0, 1'b0, 16'h0001, 23'h8000, 5'h0e);
		ar(CAB_OP_ADD, 2'b00, 10'h0, 1'b0, 16'h8001, 23'h0, 5'h13);
		ar(CAB_OP_ADD_WITH_CARRY, 2'b00, 10'h0, 1'b0, 16'h0, 23'h8000, 5'h0e);
		ar(CAB_OP_ADD_WITH_CARRY, 2'b00, 10'h0, 1'b0, 16'h8001, 23'h0, 5'h03);
		ar(CAB_OP_ASR1, 2'b00, 10'h0, 1'b0, 16'h8001, 23'hc000, 5'h07);
		bo(CAB_OP_BIT_SET, 16'h0000, 4'hf, 23'h8000);
		bo(CAB_OP_BIT_CLEAR, 16'hffff, 4'h0, 23'hfffe);
		bo(CAB_OP_BIT_TOGGLE, 16'h00ff, 4'h7, 23'h007f);
		for (int b = 0; b < 4; b++) begin
			do_op(CAB_OP_BIT_TEST_SKIP_CLEAR, CAB_CC_C, 2'b00, 10'h0, 1'b0, CAB_SZ_WORD,
				b[1] ? 16'h8000 : 16'h7fff, 4'hf, b[0], CAB_OP_BIT_SET);
			chk(g_we2, 23'(b[1]));
			chk(g_bz1, 23'(!b[1]));
			chk(g_bz2, 23'(b == 1));
			chk(g_fl, 23'(fl));
		end
		for (int k = 0; k < 2; k++) begin
			do_op(k ? CAB_OP_BRANCH_COMPUTED : CAB_OP_BRANCH_ALWAYS, CAB_CC_C, 2'b00, 10'h0, 1'b0,
				CAB_SZ_WORD, 16'h3457, 4'h0, 1'b0, CAB_OP_BIT_SET);
			chk(g_pcl, 23'h1);
			chk(g_we2, 23'h0);
			chk(g_bz1, 23'h1);
			chk(g_pc, k ? 23'h007ffe : 23'h243456);
		end
		// Working register zero holds 7fff here; shift it by a literal of four.
		do_op(CAB_OP_ASR_BY_REG, CAB_CC_C, 2'b01, 10'h004, 1'b0, CAB_SZ_WORD, 16'h0, 4'h0, 1'b0,
			CAB_OP_NOP);
		chk(g_fl, 23'h03);
		chk(g_ea, 23'h07ff);
		do_op(CAB_OP_ADD, CAB_CC_C, 2'b00, 10'h0, 1'b0, CAB_SZ_BYTE, 16'h12f0, 4'h0, 1'b0, CAB_OP_NOP);
		chk(g_wd, 23'h12ef);
		chk(g_fl, 23'h00);
		// Register form: 07ff shifted by its own low nibble leaves zero.
		do_op(CAB_OP_ASR_BY_REG, CAB_CC_C, 2'b10, 10'h0, 1'b0, CAB_SZ_WORD, 16'h0, 4'h0, 1'b0,
			CAB_OP_NOP);
		chk(g_fl, 23'h10);
		chk(g_ea, 23'h0000);
		conclude();
	end
endmodule
